// file: rtl/qenc_top.sv
// Quadrature encoder position counter with filters, timer mode and flags.
`timescale 1ns/1ps
`default_nettype none
`include "qenc_defs.svh"
module qenc_top
   import qenc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic PHASE_A_INPUT,
   input wire logic PHASE_B_INPUT,
   input wire logic INDEX_INPUT,
   input wire logic [2:0] ENCODER_MODE_SELECT,
   input wire logic INDEX_RESET_ENABLE,
   input wire logic DIRECTION_SOURCE_SELECT,
   input wire logic DIRECTION_CONTROL,
   input wire logic [15:0] MAX_COUNT_VALUE,
   input wire logic [2:0] FILTER_CLOCK_DIVIDE,
   input wire logic FILTER_OUTPUT_ENABLE,
   input wire logic COUNT_ERROR_IRQ_DISABLE,
   input wire logic [1:0] INDEX_MATCH_VALUE,
   input wire logic STOP_IN_IDLE,
   input wire logic CPU_SLEEP,
   input wire logic CPU_IDLE,
   input wire logic POS_WRITE_EN,
   input wire logic [15:0] POS_WRITE_DATA,
   input wire logic COUNT_ERROR_CLEAR,
   input wire logic IRQ_FLAG_CLEAR,
   input wire logic GATE_ACCUM_EVENT,
   output logic [15:0] POSITION_COUNT,
   output logic COUNT_DIRECTION,
   output logic COUNT_DIRECTION_STATUS,
   output logic COUNT_ERROR_FLAG,
   output logic ENCODER_IRQ_FLAG
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------

   qenc_st_t st_r, st_nxt;
   qenc_mode_t mode;
   logic tick;
   logic [2:0] raw;
   logic [2:0] filt;
   logic pa, pb, pi;
   logic enc_mode, x4, idx_mode, tmr_mode, wrap_mode;
   logic run;
   logic a_edge, b_edge;
   logic enc_up, tmr_up, up;
   logic enc_cnt, tmr_cnt, cnt;
   logic match, qual, idx_evt;
   logic at_top, at_zero;
   logic [15:0] pos_inc, pos_dec, max_p1, nxt_cnt;
   logic roll, err_set, irq_other, irq_set;

   // ------------------------------------------------------------
   // Filter clock and noise filters
   // ------------------------------------------------------------

   // One divider feeds all three filters so they sample together.
   qenc_clkdiv u_div (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .divide_code(FILTER_CLOCK_DIVIDE),
      .tick(tick)
   );

   assign raw = {INDEX_INPUT, PHASE_B_INPUT, PHASE_A_INPUT};

   // Reset clears every filter history, so the network starts idle.
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_flt
         qenc_filter u_flt (
            .clk(REF_CLK),
            .rst(SYS_RST),
            .tick(tick),
            .din(raw[g]),
            .dout(filt[g])
         );
      end
   endgenerate

   // Filtered levels reach the counter only while the enable is set.
   // With it clear the raw pins pass straight through.
   assign pa = FILTER_OUTPUT_ENABLE ? filt[0] : raw[0];
   assign pb = FILTER_OUTPUT_ENABLE ? filt[1] : raw[1];
   assign pi = FILTER_OUTPUT_ENABLE ? filt[2] : raw[2];

   // ------------------------------------------------------------
   // Mode decode and power states
   // ------------------------------------------------------------

   // Codes 010 and 011 fall into neither group and act as off.
   assign mode = qenc_mode_t'(ENCODER_MODE_SELECT);
   assign enc_mode = ENCODER_MODE_SELECT[2];
   assign x4 = ENCODER_MODE_SELECT[1];
   assign idx_mode = enc_mode & ~ENCODER_MODE_SELECT[0];
   assign tmr_mode = (mode == QENC_TIMER);
   assign wrap_mode = tmr_mode | (enc_mode & ENCODER_MODE_SELECT[0]);

   // Sleep always halts; idle halts only when asked to.
   assign run = ~CPU_SLEEP & ~(CPU_IDLE & STOP_IN_IDLE);

   // ------------------------------------------------------------
   // Edge and direction detection
   // ------------------------------------------------------------

   assign a_edge = pa ^ st_r.a_p;
   assign b_edge = pb ^ st_r.b_p;

   // A leading B gives A equal to the old B inverted on each edge.
   assign enc_up = pa ^ st_r.b_p;

   // x2 counts only A edges; x4 counts both phases.
   assign enc_cnt = enc_mode & run & (a_edge | (x4 & b_edge));

   // Timer clocks on rising A, direction from B or the control bit.
   assign tmr_up = DIRECTION_SOURCE_SELECT ? pb : DIRECTION_CONTROL;
   assign tmr_cnt = tmr_mode & run & pa & ~st_r.a_p;

   assign up = tmr_mode ? tmr_up : enc_up;
   assign cnt = enc_cnt | tmr_cnt;

   // ------------------------------------------------------------
   // Index qualification
   // ------------------------------------------------------------

   // x4 checks both phases; x2 checks the one phase chosen.
   always_comb begin
      if (x4) begin
         match = ({pb, pa} == INDEX_MATCH_VALUE);
      end else begin
         match = ((INDEX_MATCH_VALUE[1] ? pb : pa) == INDEX_MATCH_VALUE[0]);
      end
   end

   // Only the leading edge of a qualified pulse counts as an event.
   assign qual = pi & match;
   assign idx_evt = idx_mode & run & qual & ~st_r.q_p;

   // ------------------------------------------------------------
   // Counter arithmetic
   // ------------------------------------------------------------

   assign at_top = (st_r.pos == MAX_COUNT_VALUE);
   assign at_zero = (st_r.pos == `QENC_POS_RST);
   assign pos_inc = st_r.pos + `QENC_POS_ONE;
   assign pos_dec = st_r.pos - `QENC_POS_ONE;
   assign max_p1 = MAX_COUNT_VALUE + `QENC_POS_ONE;

   // Max-count and timer modes fold at the period value.
   // Index modes wrap freely through the full 16-bit range.
   always_comb begin
      if (up) begin
         nxt_cnt = (wrap_mode & at_top) ? `QENC_POS_RST : pos_inc;
      end else begin
         nxt_cnt = (wrap_mode & at_zero) ? MAX_COUNT_VALUE : pos_dec;
      end
   end

   // Period match or rollover event; never raised in index modes.
   assign roll = cnt & wrap_mode & (up ? at_top : at_zero);

   // Error compare applies only to the index-reset modes.
   assign err_set = cnt & idx_mode &
      (up ? (nxt_cnt == max_p1) : (nxt_cnt == `QENC_ERR_DOWN));

   // All sources merge into one flag; the error source can be masked.
   assign irq_other = roll | idx_evt | GATE_ACCUM_EVENT;
   assign irq_set = irq_other | (err_set & ~COUNT_ERROR_IRQ_DISABLE);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------

   // Software write beats index clear, which beats a count step.
   // The count register is shared, so mode changes never touch it.
   always_comb begin
      st_nxt = st_r;
      st_nxt.a_p = pa;
      st_nxt.b_p = pb;
      st_nxt.q_p = qual;
      if (POS_WRITE_EN) begin
         st_nxt.pos = POS_WRITE_DATA;
      end else if (idx_evt & INDEX_RESET_ENABLE) begin
         st_nxt.pos = `QENC_POS_RST;
      end else if (cnt) begin
         st_nxt.pos = nxt_cnt;
      end
      // A set in the same cycle as a clear wins.
      if (err_set) begin
         st_nxt.err = 1'b1;
      end else if (COUNT_ERROR_CLEAR) begin
         st_nxt.err = 1'b0;
      end
      if (irq_set) begin
         st_nxt.irq = 1'b1;
      end else if (IRQ_FLAG_CLEAR) begin
         st_nxt.irq = 1'b0;
      end
      // Encoder modes keep the direction of the last counted step; timer mode follows the timer direction every cycle.
      if (enc_cnt) begin
         st_nxt.dir = enc_up;
      end else if (tmr_mode) begin
         st_nxt.dir = tmr_up;
      end
   end

   // ------------------------------------------------------------
   // State register and outputs
   // ------------------------------------------------------------

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Pin and status bit share one flop so they never disagree.
   assign POSITION_COUNT = st_r.pos;
   assign COUNT_DIRECTION = st_r.dir;
   assign COUNT_DIRECTION_STATUS = st_r.dir;
   assign COUNT_ERROR_FLAG = st_r.err;
   assign ENCODER_IRQ_FLAG = st_r.irq;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------

   chk_err_mode_gate: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (!$past(COUNT_ERROR_FLAG) && COUNT_ERROR_FLAG) |-> $past(idx_mode))
      else $error("Count error set outside the index-reset modes.");

   chk_err_raises_irq: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (err_set && !COUNT_ERROR_IRQ_DISABLE) |=> (ENCODER_IRQ_FLAG && COUNT_ERROR_FLAG))
      else $error("Unmasked count error did not raise the flags.");

   chk_err_irq_mask: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (err_set && COUNT_ERROR_IRQ_DISABLE && !irq_other && !ENCODER_IRQ_FLAG)
      |=> (!ENCODER_IRQ_FLAG && COUNT_ERROR_FLAG))
      else $error("Masked count error still raised the interrupt.");

   chk_idx_no_roll: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (idx_mode && cnt && !POS_WRITE_EN && !idx_evt)
      |=> (POSITION_COUNT == ($past(up) ? $past(pos_inc) : $past(pos_dec))))
      else $error("Index-mode counter folded instead of wrapping.");

   chk_err_sticky: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (COUNT_ERROR_FLAG && !COUNT_ERROR_CLEAR) |=> COUNT_ERROR_FLAG)
      else $error("Count error flag dropped without a clear.");

   chk_index_clear: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (idx_evt && INDEX_RESET_ENABLE && !POS_WRITE_EN)
      |=> (POSITION_COUNT == `QENC_POS_RST) && ENCODER_IRQ_FLAG)
      else $error("Qualified index did not clear the counter.");

   chk_max_fold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (wrap_mode && cnt && up && at_top && !POS_WRITE_EN)
      |=> (POSITION_COUNT == `QENC_POS_RST) && ENCODER_IRQ_FLAG)
      else $error("Count did not fold to zero at the period.");

   chk_dir_pin: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      enc_cnt |=> (COUNT_DIRECTION == $past(enc_up)) && COUNT_DIRECTION_STATUS == COUNT_DIRECTION)
      else $error("Direction pin does not follow the phase order.");

   chk_timer_step: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (tmr_cnt && !DIRECTION_SOURCE_SELECT && DIRECTION_CONTROL && !at_top && !POS_WRITE_EN)
      |=> POSITION_COUNT == $past(pos_inc))
      else $error("Timer did not step up on a rising phase A.");

   chk_sleep_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (CPU_SLEEP && !POS_WRITE_EN) [*2] |-> $stable(POSITION_COUNT))
      else $error("Counter moved while asleep.");

   chk_idle_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (CPU_IDLE && STOP_IN_IDLE && !POS_WRITE_EN) |=> $stable(POSITION_COUNT))
      else $error("Counter moved in idle with stop-in-idle set.");

   chk_irq_sticky: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (ENCODER_IRQ_FLAG && !IRQ_FLAG_CLEAR) |=> ENCODER_IRQ_FLAG)
      else $error("Interrupt flag dropped without a clear.");

endmodule : qenc_top
`default_nettype wire

// file: include/qenc_defs.svh
// Constants for the quadrature encoder block: reset values, codes and timing counts.
//
// Overview of operation
// - Error check only in index-reset modes.
// - Error at 0xFFFF down or max+1 up.
// - Error irq disable suppresses interrupt, not flag.
// - After error keep counting; rollover raises nothing.
// - Error flag sticky; hardware sets, software clears.
// - Index reset enable clears counter on index.
// - Index reset needs phases matching match value.
// - x4: upper bit is B, lower A.
// - x2: upper bit picks phase, lower level.
// - Index modes interrupt on qualified index pulse.
// - Direction drives pin and status bit.
// - Codes 100/101 count phase A edges only.
// - Codes 110/111 count every A and B edge.
// - A leading B counts up, lagging down.
// - Filter output changes after three stable samples.
// - Filter clock divided from cycle clock by field.
// - Filtered inputs used only with output enable.
// - Timer counts phase A rises, period is max.
// - Timer direction from phase B or direction bit.
// - Mode switches leave count register untouched.
// - Sleep halts all counting, state kept.
// - Idle halts counting only with stop-in-idle set.
// - One shared sticky interrupt flag, software cleared.
`ifndef QENC_DEFS_SVH
`define QENC_DEFS_SVH

// Reset and compare values of the count register.
`define QENC_POS_RST 16'h0000
`define QENC_POS_ONE 16'h0001
`define QENC_ERR_DOWN 16'hFFFF
`define QENC_MAX_RST 16'hFFFF

// Filter: samples that must agree before the output moves.
`define QENC_FLT_SAMPLES 3

// Filter clock divide limits, ratio minus one, per divide code.
`define QENC_DIV_LIM0 8'h00
`define QENC_DIV_LIM1 8'h01
`define QENC_DIV_LIM2 8'h03
`define QENC_DIV_LIM3 8'h0F
`define QENC_DIV_LIM4 8'h1F
`define QENC_DIV_LIM5 8'h3F
`define QENC_DIV_LIM6 8'h7F
`define QENC_DIV_LIM7 8'hFF

`endif

// file: include/qenc_pkg.sv
// Types shared by the quadrature encoder modules.
`include "qenc_defs.svh"
package qenc_pkg;

   // Mode select codes; 010 and 011 behave as off.
   typedef enum logic [2:0] {
      QENC_OFF = 3'h0,
      QENC_TIMER = 3'h1,
      QENC_X2_IDX = 3'h4,
      QENC_X2_MAX = 3'h5,
      QENC_X4_IDX = 3'h6,
      QENC_X4_MAX = 3'h7
   } qenc_mode_t;

   typedef struct packed {
      logic [`QENC_FLT_SAMPLES-1:0] hist;
      logic out;
   } qenc_flt_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } qenc_div_t;

   typedef struct packed {
      logic [15:0] pos;
      logic err;
      logic irq;
      logic dir;
      logic a_p;
      logic b_p;
      logic q_p;
   } qenc_st_t;

endpackage : qenc_pkg

// file: rtl/qenc_clkdiv.sv
// Filter clock divider producing a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
`include "qenc_defs.svh"
module qenc_clkdiv
   import qenc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] divide_code,
   output logic tick
);
   qenc_div_t st_r, st_nxt;
   logic [7:0] lim;

   // Code to limit; a lower code mid-count ends the period early, a higher one stretches it.
   always_comb begin
      case (divide_code)
         3'h0: lim = `QENC_DIV_LIM0;
         3'h1: lim = `QENC_DIV_LIM1;
         3'h2: lim = `QENC_DIV_LIM2;
         3'h3: lim = `QENC_DIV_LIM3;
         3'h4: lim = `QENC_DIV_LIM4;
         3'h5: lim = `QENC_DIV_LIM5;
         3'h6: lim = `QENC_DIV_LIM6;
         default: lim = `QENC_DIV_LIM7;
      endcase
      st_nxt = st_r;
      st_nxt.tick = (st_r.cnt >= lim);
      st_nxt.cnt = st_nxt.tick ? 8'h00 : st_r.cnt + 8'h01;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign tick = st_r.tick;

endmodule : qenc_clkdiv
`default_nettype wire

// file: rtl/qenc_filter.sv
// Three-sample digital noise filter for one encoder input.
`timescale 1ns/1ps
`default_nettype none
`include "qenc_defs.svh"
module qenc_filter
   import qenc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic din,
   output logic dout
);
   localparam int N = `QENC_FLT_SAMPLES;
   qenc_flt_t st_r, st_nxt;

   // Sample on the filter tick; move only when every sample agrees.
   always_comb begin
      st_nxt = st_r;
      if (tick) begin
         st_nxt.hist = {st_r.hist[N-2:0], din};
         if (&st_nxt.hist) begin
            st_nxt.out = 1'b1;
         end else if (~|st_nxt.hist) begin
            st_nxt.out = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign dout = st_r.out;

   chk_filter_stable: assert property (@(posedge clk) disable iff (rst)
      (st_r.out != $past(st_r.out)) |-> (st_r.hist == {N{st_r.out}}))
      else $error("Filter output moved without three agreeing samples.");

endmodule : qenc_filter
`default_nettype wire

// file: verif/qenc_enc_model.sv
// Behavioural incremental encoder that drives phase A, phase B and index levels.
`timescale 1ns/1ps
`default_nettype none
module qenc_enc_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic step_req,
   input wire logic step_fwd,
   input wire logic idx_req,
   output logic phase_a,
   output logic phase_b,
   output logic index
);
   logic [1:0] st_r;

   // One quadrature state per request; the encoder drives all three lines at all times.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= 2'h0;
         index <= 1'b0;
      end else begin
         if (step_req) begin
            st_r <= step_fwd ? st_r + 2'h1 : st_r - 2'h1;
         end
         index <= idx_req;
      end
   end

   // Gray order 00, 10, 11, 01 going forward, so phase A leads phase B on the way up.
   assign phase_a = st_r[1] ^ st_r[0];
   assign phase_b = st_r[1];
endmodule : qenc_enc_model
`default_nettype wire

// file: verif/quadrature_encoder_interface_test.sv
// Self-checking bench for the quadrature encoder block driven by an encoder model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH %0t got %h expected %h", $time, g, e); end end
module quadrature_encoder_interface_test
   import qenc_pkg::*;
;
   logic ref_clk;
   logic sys_rst;
   logic [2:0] mode;
   logic [2:0] fdiv;
   logic [1:0] match_val;
   logic [15:0] max_cnt, pwd, pos;
   logic idx_en, dir_src, dir_ctl, fen, err_mask, sidl, slp, idl, pwe, eclr, iclr, gate;
   logic stp, fwd, idxr, pa, pb, pi, dir, dirst, err, irq;
   int errors, n_tests;

   qenc_enc_model i_enc (.clk(ref_clk), .rst(sys_rst), .step_req(stp), .step_fwd(fwd),
      .idx_req(idxr), .phase_a(pa), .phase_b(pb), .index(pi));

   qenc_top i_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .PHASE_A_INPUT(pa),
      .PHASE_B_INPUT(pb), .INDEX_INPUT(pi), .ENCODER_MODE_SELECT(mode),
      .INDEX_RESET_ENABLE(idx_en), .DIRECTION_SOURCE_SELECT(dir_src),
      .DIRECTION_CONTROL(dir_ctl), .MAX_COUNT_VALUE(max_cnt), .FILTER_CLOCK_DIVIDE(fdiv),
      .FILTER_OUTPUT_ENABLE(fen), .COUNT_ERROR_IRQ_DISABLE(err_mask),
      .INDEX_MATCH_VALUE(match_val),
      .STOP_IN_IDLE(sidl), .CPU_SLEEP(slp), .CPU_IDLE(idl), .POS_WRITE_EN(pwe),
      .POS_WRITE_DATA(pwd), .COUNT_ERROR_CLEAR(eclr), .IRQ_FLAG_CLEAR(iclr),
      .GATE_ACCUM_EVENT(gate), .POSITION_COUNT(pos), .COUNT_DIRECTION(dir),
      .COUNT_DIRECTION_STATUS(dirst), .COUNT_ERROR_FLAG(err), .ENCODER_IRQ_FLAG(irq));

   // ------------------------------------------------------------
   // Helpers; each ends 1 ns past an edge so outputs have settled.
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   // Steps are two cycles apart, so each phase level lasts four cycles, which the filter passes at divide code 0.
   task automatic step(input int n, input logic f);
      repeat (n) begin
         @(posedge ref_clk);
         stp <= 1'b1;
         fwd <= f;
         @(posedge ref_clk);
         stp <= 1'b0;
      end
      cyc(4);
   endtask : step

   task automatic clr(input logic e, input logic i);
      @(posedge ref_clk);
      eclr <= e;
      iclr <= i;
      @(posedge ref_clk);
      eclr <= 1'b0;
      iclr <= 1'b0;
      cyc(2);
   endtask : clr

   task automatic wr(input logic [15:0] v);
      @(posedge ref_clk);
      pwe <= 1'b1;
      pwd <= v;
      @(posedge ref_clk);
      pwe <= 1'b0;
      cyc(2);
   endtask : wr

   task automatic idx_pulse;
      @(posedge ref_clk);
      idxr <= 1'b1;
      repeat (3) @(posedge ref_clk);
      idxr <= 1'b0;
      cyc(4);
   endtask : idx_pulse

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_count;
      @(posedge ref_clk);
      mode <= QENC_X4_MAX;
      wr(16'h0100);
      step(8, 1'b1);
      `CHK({pos, dir, dirst}, {16'h0108, 2'b11})
      step(4, 1'b0);
      `CHK({pos, dir, dirst, irq}, {16'h0104, 3'b000})
      @(posedge ref_clk);
      mode <= QENC_X2_MAX;
      step(4, 1'b1);
      `CHK(pos, 16'h0106)
   endtask : t_count

   // Index qualification table; the model rests with both phases low.
   task automatic t_index;
      logic [1:0] tv [7] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h1, 2'h2, 2'h0};
      logic [6:0] te = 7'b1100100;
      @(posedge ref_clk);
      idx_en <= 1'b1;
      for (int k = 0; k < 7; k++) begin
         @(posedge ref_clk);
         mode <= (k < 3) ? QENC_X4_IDX : QENC_X2_IDX;
         match_val <= tv[k];
         wr(16'h0055);
         clr(1'b1, 1'b1);
         idx_pulse();
         `CHK({pos, irq}, {te[k] ? 16'h0000 : 16'h0055, te[k]})
      end
      @(posedge ref_clk);
      mode <= QENC_X4_IDX;
      idx_en <= 1'b0;
      wr(16'h0055);
      clr(1'b1, 1'b1);
      idx_pulse();
      `CHK({pos, irq}, {16'h0055, 1'b1})
   endtask : t_index

   task automatic t_error;
      @(posedge ref_clk);
      max_cnt <= 16'h0010;
      wr(16'h0000);
      clr(1'b1, 1'b1);
      step(1, 1'b0);
      `CHK({pos, err, irq}, {16'hFFFF, 2'b11})
      step(1, 1'b0);
      `CHK({pos, err}, {16'hFFFE, 1'b1})
      clr(1'b1, 1'b1);
      step(2, 1'b1);
      `CHK({pos, err, irq}, {16'h0000, 2'b00})
      wr(16'h0010);
      step(1, 1'b1);
      `CHK({pos, err, irq}, {16'h0011, 2'b11})
      clr(1'b1, 1'b1);
      @(posedge ref_clk);
      err_mask <= 1'b1;
      step(1, 1'b0);
      wr(16'h0000);
      step(1, 1'b0);
      `CHK({pos, err, irq}, {16'hFFFF, 2'b10})
      clr(1'b1, 1'b1);
      @(posedge ref_clk);
      err_mask <= 1'b0;
      mode <= QENC_X4_MAX;
      wr(16'h0000);
      step(1, 1'b0);
      `CHK({pos, err, irq}, {16'h0010, 2'b01})
      step(2, 1'b1);
      `CHK(pos, 16'h0001)
   endtask : t_error

   // Timer counts rising phase A edges: four model steps give one edge.
   task automatic t_timer;
      @(posedge ref_clk);
      mode <= QENC_TIMER;
      dir_ctl <= 1'b1;
      wr(16'h000F);
      clr(1'b1, 1'b1);
      step(8, 1'b1);
      `CHK({pos, irq, dir}, {16'h0000, 2'b11})
      @(posedge ref_clk);
      dir_ctl <= 1'b0;
      step(4, 1'b1);
      `CHK({pos, dir}, {16'h0010, 1'b0})
      @(posedge ref_clk);
      dir_src <= 1'b1;
      dir_ctl <= 1'b1;
      step(4, 1'b1);
      `CHK(pos, 16'h000F)
      @(posedge ref_clk);
      mode <= QENC_OFF;
      step(4, 1'b1);
      `CHK(pos, 16'h000F)
      @(posedge ref_clk);
      mode <= 3'h3;
      step(4, 1'b1);
      `CHK(pos, 16'h000F)
      @(posedge ref_clk);
      mode <= QENC_X4_MAX;
      cyc(2);
      `CHK(pos, 16'h000F)
   endtask : t_timer

   task automatic t_power;
      @(posedge ref_clk);
      max_cnt <= 16'hFFFF;
      slp <= 1'b1;
      step(4, 1'b1);
      `CHK(pos, 16'h000F)
      @(posedge ref_clk);
      slp <= 1'b0;
      idl <= 1'b1;
      sidl <= 1'b1;
      step(4, 1'b1);
      `CHK(pos, 16'h000F)
      @(posedge ref_clk);
      sidl <= 1'b0;
      step(4, 1'b1);
      `CHK(pos, 16'h0013)
      @(posedge ref_clk);
      idl <= 1'b0;
      mode <= QENC_OFF;
      clr(1'b0, 1'b1);
      @(posedge ref_clk);
      gate <= 1'b1;
      @(posedge ref_clk);
      gate <= 1'b0;
      cyc(2);
      `CHK(irq, 1'b1)
      clr(1'b0, 1'b1);
      `CHK(irq, 1'b0)
   endtask : t_power

   // A two-sample pulse must vanish; a held level appears only after three filter ticks.
   task automatic t_filter;
      int r;
      @(posedge ref_clk);
      mode <= QENC_X4_MAX;
      fen <= 1'b1;
      fdiv <= 3'h0;
      wr(16'h0020);
      @(posedge ref_clk);
      stp <= 1'b1;
      fwd <= 1'b1;
      @(posedge ref_clk);
      stp <= 1'b0;
      @(posedge ref_clk);
      stp <= 1'b1;
      fwd <= 1'b0;
      @(posedge ref_clk);
      stp <= 1'b0;
      cyc(8);
      `CHK(pos, 16'h0020)
      for (int c = 0; c < 8; c++) begin
         r = (c < 3) ? (1 << c) : (1 << (c + 1));
         @(posedge ref_clk);
         fdiv <= c[2:0];
         stp <= 1'b1;
         fwd <= 1'b1;
         @(posedge ref_clk);
         stp <= 1'b0;
         cyc(r);
         if (c > 0) `CHK(pos, 16'h0020 + c[15:0])
         cyc(3 * r + 8);
         `CHK(pos, 16'h0021 + c[15:0])
      end
      @(posedge ref_clk);
      fen <= 1'b0;
   endtask : t_filter

   task automatic stop_test;
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // Free-running 40 MHz reference clock.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Main sequence: reset, then every scenario in turn.
   initial begin
      errors = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      mode = QENC_OFF;
      fdiv = 3'h0;
      match_val = 2'h0;
      max_cnt = 16'hFFFF;
      pwd = 16'h0000;
      {idx_en, dir_src, dir_ctl, fen, err_mask, sidl, slp, idl, pwe, eclr, iclr, gate} = 12'h000;
      {stp, fwd, idxr} = 3'h0;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      cyc(2);
      `CHK({pos, dir, err, irq}, {16'h0000, 3'b000})
      t_count();
      t_index();
      t_error();
      t_timer();
      t_power();
      t_filter();
      stop_test();
   end

   // Watchdog well beyond the few thousand cycles the scenarios need.
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      stop_test();
   end
endmodule : quadrature_encoder_interface_test
`default_nettype wire
